// ### verilog/startup_seq_params.svh
// timing counts, reset values and encodings for the start-up sequencer
`ifndef STARTUP_SEQ_PARAMS_SVH
`define STARTUP_SEQ_PARAMS_SVH

`define OSC_PERIOD_NS        10
`define WD_PULSE_OSC         512
`define WD_PULSE_CYC         (`WD_PULSE_OSC)
`define BUS_DELAY_OSC        32
`define BUS_DELAY_CYC        (`BUS_DELAY_OSC)
`define BOOT_HOLD_OSC        200
`define PLL_LOCK_OSC         131072
`define WD_CNT_W             10
`define BUS_CNT_W            6
`define LOCK_CNT_W           18
`define PLL_REG_W            16
`define PLL_MULT_LSB         1
`define PLL_MULT_MSB         5
`define PLL_MULT_RESET       5'h00
`define CLKOUT_DIV_RESET     2'h0
`define CLKOUT_DIV_BY4       2'h0
`define CLKOUT_DIV_BY2       2'h1
`define BOOT_PIN_W           4

`endif

// ### verilog/startup_seq_pkg.sv
// shared types of the start-up sequencer
package startup_seq_pkg;

    typedef enum logic [1:0] {
        PLL_HALF,
        PLL_LOCKING,
        PLL_MULTIPLIED
    } pll_phase_t;

    typedef struct packed {
        logic [4:0] numerator;
        logic [1:0] denominator;
    } clock_ratio_t;

endpackage

// ### verilog/cycle_timer.sv
// one-shot down counter: busy for length cycles, then a done pulse
`timescale 1ns/10ps
module cycle_timer #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         clear,
    input  wire logic         start,
    input  wire logic [W-1:0] length,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] count;

    always_ff @(posedge clk) begin
        if (!rstn || clear) begin
            count <= '0;
        end else if (start) begin
            count <= length;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || clear) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= start || (count > {{(W-1){1'b0}}, 1'b1});
            done <= !start && (count == {{(W-1){1'b0}}, 1'b1});
        end
    end
endmodule

// ### verilog/reset_clock_startup_sequencer.sv
// reset and clock start-up sequencer running on the oscillator clock
//
// What this block does
// - watchdog firing produces a reset pulse of 512 oscillator cycles.
// - bus activity becomes valid 32 oscillator cycles after reset release.
// - at power-up the system clock runs at half the oscillator clock.
// - clock-out divide resets to 0, meaning clock output is system clock over 4 at half rate, oscillator clock over 4 once multiplied.
// - writing PLL control starts a lock phase with system clock at half rate.
// - lock phase lasts 131072 oscillator cycles, then programmed multiple applies.
// - PLL value 0x0004 gives twice, 0x0008 four times the oscillator clock.
// - after release, boot-mode pins are sampled and the boot branch is chosen.
`timescale 1ns/10ps
`include "startup_seq_params.svh"
module reset_clock_startup_sequencer #(
    parameter int PLL_LOCK_CYC = `PLL_LOCK_OSC
) (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     device_reset_pin_n,
    input  wire logic                     watchdog_fire,
    input  wire logic                     pll_write,
    input  wire logic [`PLL_REG_W-1:0]    pll_value,
    input  wire logic [1:0]               clock_out_divide_field,
    input  wire logic [`BOOT_PIN_W-1:0]   boot_mode_pins,
    output logic                          internal_reset_n,
    output logic                          watchdog_reset_n,
    output logic                          bus_valid,
    output logic                          boot_valid,
    output logic [`BOOT_PIN_W-1:0]        boot_mode,
    output logic                          pll_locking,
    output startup_seq_pkg::clock_ratio_t system_clock_ratio,
    output logic                          system_clock_en,
    output logic                          clock_output_pin
);
    logic                    pin_meta;
    logic                    pin_sync;
    logic [`BOOT_PIN_W-1:0]  boot_meta;
    logic [`BOOT_PIN_W-1:0]  boot_sync;
    logic                    hold_reset;
    logic                    hold_prev;
    logic                    release_pulse;
    logic                    wd_busy;
    logic                    wd_start;
    logic                    bus_done;
    logic                    lock_busy;
    logic                    lock_done;
    logic [4:0]              pll_mult;
    logic [4:0]              pending_mult;
    logic                    half_rate;
    logic [1:0]              co_div;
    logic                    co_count;
    logic                    co_limit;
    startup_seq_pkg::pll_phase_t phase;

    // two-stage synchroniser for the reset pin; resets to the asserted level
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= device_reset_pin_n;
            pin_sync <= pin_meta;
        end
    end

    // boot straps: only the synchronised copy is ever captured
    always_ff @(posedge clk) begin
        if (!rstn) begin
            boot_meta <= '0;
            boot_sync <= '0;
        end else begin
            boot_meta <= boot_mode_pins;
            boot_sync <= boot_meta;
        end
    end

    // a watchdog pulse retriggered mid-pulse would stretch it, so it is ignored
    assign wd_start      = watchdog_fire && !wd_busy && pin_sync;
    assign hold_reset    = !pin_sync || wd_busy || wd_start;
    assign release_pulse = hold_prev && !hold_reset;

    cycle_timer #(.W(`WD_CNT_W)) u_wd_timer (
        .clk    (clk),
        .rstn   (rstn),
        .clear  (!pin_sync),
        .start  (wd_start),
        .length (`WD_CNT_W'(`WD_PULSE_CYC)),
        .busy   (wd_busy),
        .done   ()
    );

    // counts from the edge the reset is seen gone; the output flop adds one cycle
    cycle_timer #(.W(`BUS_CNT_W)) u_bus_timer (
        .clk    (clk),
        .rstn   (rstn),
        .clear  (hold_reset),
        .start  (release_pulse),
        .length (`BUS_CNT_W'(`BUS_DELAY_CYC)),
        .busy   (),
        .done   (bus_done)
    );

    // a write during the lock phase reloads the full length
    cycle_timer #(.W(`LOCK_CNT_W)) u_lock_timer (
        .clk    (clk),
        .rstn   (rstn),
        .clear  (hold_reset),
        .start  (pll_write && !hold_reset),
        .length (`LOCK_CNT_W'(PLL_LOCK_CYC)),
        .busy   (lock_busy),
        .done   (lock_done)
    );

    // registered so the reset outputs come straight from flops
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_prev        <= 1'b1;
            internal_reset_n <= 1'b0;
            watchdog_reset_n <= 1'b1;
        end else begin
            hold_prev        <= hold_reset;
            internal_reset_n <= !hold_reset;
            watchdog_reset_n <= !(wd_busy || wd_start);
        end
    end

    // the boot code runs once the bus is valid, well inside the pin hold window
    always_ff @(posedge clk) begin
        if (!rstn || hold_reset) begin
            bus_valid  <= 1'b0;
            boot_valid <= 1'b0;
            boot_mode  <= '0;
        end else if (bus_done) begin
            bus_valid  <= 1'b1;
            boot_valid <= 1'b1;
            boot_mode  <= boot_sync;
        end
    end

    // multiplier is the register value halved: 0x0004 -> x2, 0x0008 -> x4
    always_ff @(posedge clk) begin
        if (!rstn || hold_reset) begin
            pending_mult <= `PLL_MULT_RESET;
            pll_mult     <= `PLL_MULT_RESET;
        end else begin
            if (pll_write) begin
                pending_mult <= pll_value[`PLL_MULT_MSB:`PLL_MULT_LSB];
            end

            if (pll_write) begin
                pll_mult <= `PLL_MULT_RESET;
            end else if (lock_done) begin
                pll_mult <= pending_mult;
            end
        end
    end

    // a zero multiplier leaves the PLL off, so the lock ends back at half rate
    always_ff @(posedge clk) begin
        if (!rstn || hold_reset) begin
            phase <= startup_seq_pkg::PLL_HALF;
        end else if (pll_write || lock_busy) begin
            phase <= startup_seq_pkg::PLL_LOCKING;
        end else if (lock_done) begin
            phase <= (pending_mult == 5'h00) ? startup_seq_pkg::PLL_HALF : startup_seq_pkg::PLL_MULTIPLIED;
        end
    end

    always_comb begin
        case (phase)
            startup_seq_pkg::PLL_HALF:       half_rate = 1'b1;
            startup_seq_pkg::PLL_LOCKING:    half_rate = 1'b1;
            startup_seq_pkg::PLL_MULTIPLIED: half_rate = 1'b0;
            default:                         half_rate = 1'b1;
        endcase
    end

    // a multiplied system clock cannot be an enable; the tick then fires every cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            system_clock_en    <= 1'b0;
            pll_locking        <= 1'b0;
            system_clock_ratio <= '{numerator: 5'h01, denominator: 2'h2};
        end else begin
            system_clock_en <= half_rate ? !system_clock_en : 1'b1;
            pll_locking     <= (phase == startup_seq_pkg::PLL_LOCKING);
            if (half_rate) begin
                system_clock_ratio <= '{numerator: 5'h01, denominator: 2'h2};
            end else begin
                system_clock_ratio <= '{numerator: pll_mult, denominator: 2'h1};
            end
        end
    end

    // clock out toggles on system ticks; divide by 1 degrades to divide by 2
    always_ff @(posedge clk) begin
        if (!rstn || hold_reset) begin
            co_div <= `CLKOUT_DIV_RESET;
        end else begin
            co_div <= clock_out_divide_field;
        end
    end

    // fields 2 and 3 cannot beat the tick rate and act as /2
    assign co_limit = (co_div == `CLKOUT_DIV_BY4);

    always_ff @(posedge clk) begin
        if (!rstn || hold_reset) begin
            co_count         <= 1'b0;
            clock_output_pin <= 1'b0;
        end else if (system_clock_en) begin
            // a count left at 1 by a switch from /4 to /2 must not stall the pin
            if (co_count || !co_limit) begin
                co_count         <= 1'b0;
                clock_output_pin <= !clock_output_pin;
            end else begin
                co_count <= 1'b1;
            end
        end
    end
endmodule

// ### testbench/startup_checker.sv
// port assertions for the reset and clock start-up sequencer
`timescale 1ns/10ps
module startup_checker #(
    parameter int PLL_LOCK_CYC = 64
) (
    input wire logic                          clk,
    input wire logic                          rstn,
    input wire logic                          device_reset_pin_n,
    input wire logic                          pll_write,
    input wire logic [15:0]                   pll_value,
    input wire logic                          internal_reset_n,
    input wire logic                          watchdog_reset_n,
    input wire logic                          bus_valid,
    input wire logic                          pll_locking,
    input wire startup_seq_pkg::clock_ratio_t system_clock_ratio,
    input wire logic                          system_clock_en
);
    int         wd_low;
    int         lock_len;
    logic [4:0] mult;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk) wd_low <= (!rstn || watchdog_reset_n) ? 0 : wd_low + 1;
    // a write mid-lock restarts the count
    always_ff @(posedge clk) lock_len <= (!rstn || pll_write) ? 0 : lock_len + (pll_locking ? 1 : 0);
    always_ff @(posedge clk) if (pll_write && internal_reset_n) mult <= pll_value[5:1];
    AST_HOLD: assert property (!device_reset_pin_n [*4] |-> !internal_reset_n) else $error("reset not held");
    AST_DROP: assert property (!internal_reset_n |=> !bus_valid) else $error("bus valid in reset");
    AST_WD_INT: assert property (!watchdog_reset_n |-> !internal_reset_n) else $error("pulse not reset");
    AST_WD_LEN: assert property ($rose(watchdog_reset_n) |-> wd_low >= 512 && wd_low <= 514)
        else $error("watchdog pulse length");
    AST_BUS: assert property ($rose(internal_reset_n) |-> !bus_valid [*8] ##[23:28] bus_valid)
        else $error("bus valid delay");
    AST_HALF: assert property ((internal_reset_n && system_clock_ratio == 7'h06) [*3]
        |-> system_clock_en != $past(system_clock_en)) else $error("half rate tick");
    AST_LOCK_HALF: assert property (pll_locking |-> system_clock_ratio == 7'h06) else $error("lock rate");
    AST_LOCK_LEN: assert property ($fell(pll_locking) && internal_reset_n
        |-> lock_len >= PLL_LOCK_CYC - 1 && lock_len <= PLL_LOCK_CYC + 2) else $error("lock length");
    AST_MULT: assert property ($fell(pll_locking) && internal_reset_n
        |-> ##[0:2] system_clock_ratio == ((mult == 5'h00) ? 7'h06 : {mult, 2'h1})) else $error("multiplied ratio");
endmodule

// ### testbench/board_supervisor_model.sv
// board reset supervisor and boot strap drivers
`timescale 1ns/10ps
module board_supervisor_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [3:0] mode,
    output logic            pin_n,
    output logic [3:0]      pins
);
    int   cnt = 0;
    logic g;
    initial pin_n = 1'b0;
    initial pins = 4'h0;
    always @(posedge clk) begin
        g = go;
        #1;
        cnt = g ? 0 : cnt + 1;
        pin_n = (cnt >= 8);
        // straps let go after the hold: inverted every cycle, so the old value returns every other cycle
        pins = g ? mode : (cnt > 208) ? ~pins : pins;
    end
endmodule

// ### testbench/reset_clock_startup_sequencer_tb.sv
// self-checking bench for the reset and clock start-up sequencer
`timescale 1ns/10ps
module reset_clock_startup_sequencer_tb;
    localparam int LOCK = 64;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        wd_fire = 1'b0;
    logic        pll_write = 1'b0;
    logic        go = 1'b1;
    logic [15:0] pll_value = 16'h0000;
    logic [15:0] v;
    logic [1:0]  div = 2'h0;
    logic [3:0]  mode = 4'h0;
    logic        pin_n, int_n, wd_n, bus_v, boot_v, locking, en, clk_out;
    logic [3:0]  pins, boot_m;
    startup_seq_pkg::clock_ratio_t ratio;
    int          err_count = 0;
    int          checks = 0;
    int          cycles = 0;
    int          n;
    int          seed = 32'ha2241b07;
    logic [3:0]  boot_q[$];
    logic [3:0]  exp_boot;
    int          exp_mult;
    always #5 clk = ~clk;
    board_supervisor_model i_board (.clk(clk), .go(go), .mode(mode), .pin_n(pin_n), .pins(pins));
    reset_clock_startup_sequencer #(.PLL_LOCK_CYC(LOCK)) i_dut (.clk(clk), .rstn(rstn),
        .device_reset_pin_n(pin_n), .watchdog_fire(wd_fire), .pll_write(pll_write), .pll_value(pll_value),
        .clock_out_divide_field(div), .boot_mode_pins(pins), .internal_reset_n(int_n), .watchdog_reset_n(wd_n),
        .bus_valid(bus_v), .boot_valid(boot_v), .boot_mode(boot_m), .pll_locking(locking),
        .system_clock_ratio(ratio), .system_clock_en(en), .clock_output_pin(clk_out));
    task automatic end_of_test();
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    // bounded wait, cycles taken left in n
    task automatic wait_for(ref logic s, input logic val, input int lim);
        for (n = 0; s !== val && n < lim; n++) begin
            tick(1);
        end
    endtask
    task automatic toggles(input int exp);
        logic last;
        int   t;
        t = 0;
        tick(8);
        repeat (64) begin
            last = clk_out;
            tick(1);
            t += int'(clk_out !== last);
        end
        chk(16'(t), 16'(exp));
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        mode = 4'($random(seed));
        boot_q.push_back(mode);
        tick(20);
        rstn = 1'b1;
        go = 1'b0;
        wait_for(bus_v, 1'b1, 80);
        exp_boot = boot_q.pop_front();
        chk({boot_v, boot_m, ratio}, {1'b1, exp_boot, 7'h06});
        toggles(16);
        div = 2'h1;
        toggles(32);
        div = 2'h2 | 2'($random(seed));
        toggles(32);
        div = 2'h0;
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 16'h0004 : (i == 1) ? 16'h0008 : {10'h000, 5'($random(seed)) | 5'h01, 1'b0};
            pll_value = 16'h0004;
            if (i == 3) begin
                pulse(pll_write);
                tick(10);
            end
            pll_value = v;
            pulse(pll_write);
            wait_for(locking, 1'b1, 4);
            chk(ratio, 7'h06);
            wait_for(locking, 1'b0, LOCK + 8);
            chk(16'(n inside {[LOCK - 3:LOCK + 2]}), 16'h0001);
            tick(2);
            exp_mult = (v == 16'h0004) ? 2 : (v == 16'h0008) ? 4 : int'(v[5:1]);
            chk({en, ratio}, {1'b1, 5'(exp_mult), 2'h1});
            toggles(32);
        end
        // a second fire and a pll write inside the pulse must both be ignored
        pulse(wd_fire);
        wait_for(wd_n, 1'b0, 3);
        tick(100);
        pll_value = 16'h0008;
        pulse(wd_fire);
        pulse(pll_write);
        chk(int_n, 1'b0);
        wait_for(wd_n, 1'b1, 520);
        chk(16'((n + 102) inside {[510:516]}), 16'h0001);
        wait_for(bus_v, 1'b1, 60);
        chk(16'(n inside {[31:35]}), 16'h0001);
        chk({locking, ratio}, {1'b0, 7'h06});
        mode = 4'($random(seed));
        boot_q.push_back(mode);
        pulse(go);
        tick(6);
        chk({int_n, bus_v}, 2'h0);
        wait_for(bus_v, 1'b1, 60);
        exp_boot = boot_q.pop_front();
        chk({boot_m, ratio}, {exp_boot, 7'h06});
        end_of_test();
    end
endmodule
bind reset_clock_startup_sequencer startup_checker #(.PLL_LOCK_CYC(PLL_LOCK_CYC)) i_chk (.clk(clk), .rstn(rstn),
    .device_reset_pin_n(device_reset_pin_n), .pll_write(pll_write), .pll_value(pll_value),
    .internal_reset_n(internal_reset_n), .watchdog_reset_n(watchdog_reset_n), .bus_valid(bus_valid),
    .pll_locking(pll_locking), .system_clock_ratio(system_clock_ratio), .system_clock_en(system_clock_en));
